// ---- design/dupi_pkg.sv ----
// Shared constants and types for the dual channel host pin interface.
// Assumes one clock domain and host pins already synchronous to it.
package dupi_pkg;
   localparam int DUPI_DATA_W = 8;
   localparam int DUPI_ADDR_W = 3;
   localparam int DUPI_NUM_REGS = 8;
   localparam int DUPI_NUM_CHAN = 2;
   localparam int DUPI_SYNC_STAGES = 2;
   localparam logic [DUPI_ADDR_W-1:0] DUPI_MODEM_STATUS_ADDR = 3'h6;
   localparam int DUPI_MSR_CTS_BIT = 4;
   localparam int DUPI_MSR_CD_BIT = 7;
   localparam logic DUPI_SEL_CHAN_B = 1'b0;
   localparam logic DUPI_SEL_CHAN_A = 1'b1;
   localparam int DUPI_IDX_A = 0;
   localparam int DUPI_IDX_B = 1;
   localparam logic [DUPI_DATA_W-1:0] DUPI_REG_RESET = 8'h00;
   localparam logic [1:0] DUPI_MODEM_IDLE = 2'h3;

   // Modem inputs of one channel, both active low
   typedef struct packed {
      logic cd_n;
      logic cts_n;
   } dupi_modem_t;

   // One host bus cycle as seen on the pins
   typedef struct packed {
      logic [DUPI_ADDR_W-1:0] addr;
      logic cs_n;
      logic chan_sel;
      logic rd_n;
      logic wr_n;
   } dupi_host_t;
endpackage

// ---- design/dupi_top.sv ----
// Host pin interface of a dual UART: register file, channel routing, modem
// status and transmit gating. Assumes host pins are synchronous to CLK and
// held stable around the strobe edges; modem pins are asynchronous.

//////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for the modem inputs
module dupi_sync
(
   input wire logic CLK,           // System clock
   input wire logic RST_N,         // Async reset, active low
   input wire logic [1:0] D_IN,    // Asynchronous level
   output logic [1:0] Q_OUT        // Synchronised level
);
   import dupi_pkg::*;
   logic [1:0] stage1_r;
   logic [1:0] stage2_r;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         stage1_r <= DUPI_MODEM_IDLE;
         stage2_r <= DUPI_MODEM_IDLE;
      end
      else
      begin
         stage1_r <= D_IN;
         stage2_r <= stage1_r;
      end
   end

   assign Q_OUT = stage2_r;
endmodule

//////////////////////////////////////////////////////////////////////////////
// How it works
// - The three address pins pick one register inside the chosen channel.
// - A low carrier detect input means the modem sees a carrier.
// - The carrier detect level is readable in that channel's modem status.
// - Channel select low routes to channel B, high routes to channel A.
// - Channel select counts only with chip select low; otherwise nobody answers.
// - With broadcast set, one write lands in both channels regardless of select.
// - Clear to send is active low and reads back in modem status bit 4.
// - Clear to send gates transmit only while automatic flow control is enabled.
// - Data bit 0 is the least significant and first serial bit.
// - The data bus is driven only while returning read data.
// - Read strobe falling edge puts the addressed register on the bus.
// - Write strobe rising edge stores the bus into the addressed register, unless that is modem status.
module dupi_top
(
   input wire logic CLK,                                   // System clock, 40 MHz
   input wire logic RST_N,                                 // Async reset, active low
   input wire dupi_pkg::dupi_host_t HOST_BUS,              // Address, selects, strobes
   input wire logic [dupi_pkg::DUPI_DATA_W-1:0] DATA_IN,   // Data bus pin input
   output logic [dupi_pkg::DUPI_DATA_W-1:0] DATA_OUT,      // Data bus pin output
   output logic DATA_OE,                                   // High while driving the bus
   input wire dupi_pkg::dupi_modem_t MODEM_CHAN_A,         // Channel A modem inputs
   input wire dupi_pkg::dupi_modem_t MODEM_CHAN_B,         // Channel B modem inputs
   input wire logic ALT_FUNC_BCAST,                        // Broadcast write enable
   input wire logic [1:0] AUTO_CTS_EN,                     // Auto flow control, [0]=A
   input wire logic [1:0] TX_REQ,                          // Transmitter has data, [0]=A
   output logic [1:0] TX_GO,                               // Transmitter may send, [0]=A
   output logic [1:0] CARRIER_SEEN                         // Carrier present, [0]=A
);
   import dupi_pkg::*;

   ///////////////////////////////////////////////////////////////////////////
   // Synchronised modem inputs
   logic [1:0] modem_a_sync;
   logic [1:0] modem_b_sync;
   logic [DUPI_NUM_CHAN-1:0] cd_n_sync;
   logic [DUPI_NUM_CHAN-1:0] cts_n_sync;

   dupi_sync u_sync_a
   (
      .CLK(CLK),
      .RST_N(RST_N),
      .D_IN(MODEM_CHAN_A),
      .Q_OUT(modem_a_sync)
   );

   dupi_sync u_sync_b
   (
      .CLK(CLK),
      .RST_N(RST_N),
      .D_IN(MODEM_CHAN_B),
      .Q_OUT(modem_b_sync)
   );

   assign cd_n_sync = {modem_b_sync[1], modem_a_sync[1]};
   assign cts_n_sync = {modem_b_sync[0], modem_a_sync[0]};

   ///////////////////////////////////////////////////////////////////////////
   // Strobe edge detection
   logic rd_prev_r;
   logic rd_prev_nxt;
   logic wr_prev_r;
   logic wr_prev_nxt;
   logic rd_fall;
   logic wr_rise;
   logic chip_sel;

   assign chip_sel = !HOST_BUS.cs_n;
   assign rd_fall = rd_prev_r && !HOST_BUS.rd_n && chip_sel;
   assign wr_rise = !wr_prev_r && HOST_BUS.wr_n && chip_sel;

   always_comb
   begin
      rd_prev_nxt = HOST_BUS.rd_n;
      wr_prev_nxt = HOST_BUS.wr_n;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_prev_r <= 1'b1;
         wr_prev_r <= 1'b1;
      end
      else
      begin
         rd_prev_r <= rd_prev_nxt;
         wr_prev_r <= wr_prev_nxt;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Channel routing and register file
   logic [DUPI_DATA_W-1:0] regs_r [DUPI_NUM_CHAN][DUPI_NUM_REGS];
   logic [DUPI_DATA_W-1:0] regs_nxt [DUPI_NUM_CHAN][DUPI_NUM_REGS];
   logic [DUPI_NUM_CHAN-1:0] wr_chan;
   int unsigned rd_idx;

   always_comb
   begin
      rd_idx = (HOST_BUS.chan_sel == DUPI_SEL_CHAN_A) ? DUPI_IDX_A : DUPI_IDX_B;
      wr_chan = '0;
      if (ALT_FUNC_BCAST)
      begin
         wr_chan = '1;
      end
      else if (HOST_BUS.chan_sel == DUPI_SEL_CHAN_A)
      begin
         wr_chan[DUPI_IDX_A] = 1'b1;
      end
      else
      begin
         wr_chan[DUPI_IDX_B] = 1'b1;
      end
   end

   always_comb
   begin
      regs_nxt = regs_r;
      for (int c = 0; c < DUPI_NUM_CHAN; c++)
      begin
         // Modem status is read-only; writes to it are dropped
         if (wr_rise && wr_chan[c] && HOST_BUS.addr != DUPI_MODEM_STATUS_ADDR)
         begin
            regs_nxt[c][HOST_BUS.addr] = DATA_IN;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         for (int c = 0; c < DUPI_NUM_CHAN; c++)
         begin
            for (int r = 0; r < DUPI_NUM_REGS; r++)
            begin
               regs_r[c][r] <= DUPI_REG_RESET;
            end
         end
      end
      else
      begin
         regs_r <= regs_nxt;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Read path and bus drive
   logic [DUPI_DATA_W-1:0] rd_data_r;
   logic [DUPI_DATA_W-1:0] rd_data_nxt;
   logic oe_r;
   logic oe_nxt;
   logic [DUPI_DATA_W-1:0] status_word;

   always_comb
   begin
      status_word = '0;
      status_word[DUPI_MSR_CTS_BIT] = !cts_n_sync[rd_idx];
      status_word[DUPI_MSR_CD_BIT] = !cd_n_sync[rd_idx];
      rd_data_nxt = rd_data_r;
      if (rd_fall)
      begin
         if (HOST_BUS.addr == DUPI_MODEM_STATUS_ADDR)
         begin
            rd_data_nxt = status_word;
         end
         else
         begin
            rd_data_nxt = regs_r[rd_idx][HOST_BUS.addr];
         end
      end
      // Drive only between the read strobe falling and rising again
      oe_nxt = oe_r ? (!HOST_BUS.rd_n && chip_sel) : rd_fall;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_data_r <= DUPI_REG_RESET;
         oe_r <= 1'b0;
      end
      else
      begin
         rd_data_r <= rd_data_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign DATA_OUT = rd_data_r;
   assign DATA_OE = oe_r;

   ///////////////////////////////////////////////////////////////////////////
   // Transmit gating and carrier status
   logic [1:0] tx_go_r;
   logic [1:0] tx_go_nxt;
   logic [1:0] carrier_r;
   logic [1:0] carrier_nxt;

   always_comb
   begin
      for (int c = 0; c < DUPI_NUM_CHAN; c++)
      begin
         tx_go_nxt[c] = TX_REQ[c] && (!AUTO_CTS_EN[c] || !cts_n_sync[c]);
         carrier_nxt[c] = !cd_n_sync[c];
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_go_r <= '0;
         carrier_r <= '0;
      end
      else
      begin
         tx_go_r <= tx_go_nxt;
         carrier_r <= carrier_nxt;
      end
   end

   assign TX_GO = tx_go_r;
   assign CARRIER_SEEN = carrier_r;
endmodule

// ---- test/dupi_host.sv ----
// Host processor model that drives the register bus pins.
// Assumes the bench calls acc between falling clock edges and feeds Q from the bus wire.
module dupi_host
   import dupi_pkg::*;
(
   input wire logic CLK,           // System clock
   input wire logic [7:0] Q,       // Resolved data bus level
   output dupi_host_t BUS,         // Address, selects, strobes
   output logic [7:0] D            // Data the host puts on the bus
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      BUS = '1;
      D = 8'h00;
   end
   // One access; on reads the host floats the bus, modelled as the inverse of the last value
   task automatic acc(input logic w, input logic cs, input logic c, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge CLK);
      BUS.addr = a;
      BUS.chan_sel = c;
      BUS.cs_n = cs;
      BUS.wr_n = !w;
      D = w ? d : ~D;
      @(negedge CLK);
      BUS.rd_n = w;
      BUS.wr_n = 1'b1;
      repeat (2) @(negedge CLK);
      q = Q;
      BUS.rd_n = 1'b1;
      BUS.cs_n = 1'b1;
      D = ~D;
   endtask
endmodule

// ---- test/dupi_chk_assertions.sv ----
// Concurrent checks on the pins of the host interface.
// Assumes it is bound to the top module and sees only its ports.
module dupi_chk
(
   input wire logic CLK,                                   // System clock
   input wire logic RST_N,                                 // Async reset, active low
   input wire dupi_pkg::dupi_host_t HOST_BUS,              // Host pins
   input wire logic [dupi_pkg::DUPI_DATA_W-1:0] DATA_IN,   // Data bus in
   input wire logic [dupi_pkg::DUPI_DATA_W-1:0] DATA_OUT,  // Data bus out
   input wire logic DATA_OE,                               // Bus drive enable
   input wire dupi_pkg::dupi_modem_t MODEM_CHAN_A,         // Channel A modem
   input wire dupi_pkg::dupi_modem_t MODEM_CHAN_B,         // Channel B modem
   input wire logic ALT_FUNC_BCAST,                        // Broadcast write
   input wire logic [1:0] AUTO_CTS_EN,                     // Auto flow control
   input wire logic [1:0] TX_REQ,                          // Transmit request
   input wire logic [1:0] TX_GO,                           // Transmit permit
   input wire logic [1:0] CARRIER_SEEN                     // Carrier present
);
   timeunit 1ns;
   timeprecision 100ps;
   import dupi_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_rd_drive_oe: assert property ($past(HOST_BUS.rd_n) && !HOST_BUS.rd_n && !HOST_BUS.cs_n
      |=> DATA_OE) else $error("read strobe did not drive the bus");
   a_oe_release: assert property ((HOST_BUS.rd_n || HOST_BUS.cs_n) |=> !DATA_OE)
      else $error("bus driven outside a read");
   a_oe_needs_cs: assert property ($rose(DATA_OE) |-> !$past(HOST_BUS.cs_n)
      && $past(HOST_BUS.rd_n, 2)) else $error("bus drive without a selected read edge");
   a_tx_free: assert property (!AUTO_CTS_EN[0] && TX_REQ[0] |=> TX_GO[0])
      else $error("transmit held without flow control");
   a_tx_hold: assert property ((MODEM_CHAN_A.cts_n [*4]) ##0 AUTO_CTS_EN[0] |=> !TX_GO[0])
      else $error("transmit not gated by clear to send");
   a_tx_req: assert property (TX_GO[1] |-> $past(TX_REQ[1]))
      else $error("transmit permit without request");
   a_cd_seen: assert property ((!MODEM_CHAN_A.cd_n) [*4] |=> CARRIER_SEEN[0])
      else $error("low carrier input not reported");
   a_cd_idle: assert property ((MODEM_CHAN_B.cd_n [*4]) |=> !CARRIER_SEEN[1])
      else $error("high carrier input reported as carrier");
   a_cd_delay: assert property ($changed(CARRIER_SEEN[0])
      |-> CARRIER_SEEN[0] == !$past(MODEM_CHAN_A.cd_n, 3)) else $error("carrier timing off");
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the dual channel host pin interface.
// Assumes the package, the host model and the checker are compiled first.
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dupi_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic bcast = 1'b0;
   logic data_oe;
   logic [7:0] host_d, data_out, bus_w, r;
   logic [1:0] auto_cts = 2'h0, tx_req = 2'h0, tx_go, cd_seen;
   dupi_host_t host_bus;
   dupi_modem_t mod_a = 2'h3, mod_b = 2'h3;
   int n_mismatch = 0, checked = 0;
   always #12.5 CLK = ~CLK;
   assign bus_w = data_oe ? data_out : host_d;
   dupi_host i_dupi_host(.CLK(CLK), .Q(bus_w), .BUS(host_bus), .D(host_d));
   dupi_top i_dupi_top(.CLK(CLK), .RST_N(RST_N), .HOST_BUS(host_bus), .DATA_IN(bus_w),
      .DATA_OUT(data_out), .DATA_OE(data_oe), .MODEM_CHAN_A(mod_a), .MODEM_CHAN_B(mod_b),
      .ALT_FUNC_BCAST(bcast), .AUTO_CTS_EN(auto_cts), .TX_REQ(tx_req), .TX_GO(tx_go),
      .CARRIER_SEEN(cd_seen));
   task automatic wr(input logic cs, input logic c, input logic [2:0] a, input logic [7:0] d);
      logic [7:0] unused;
      i_dupi_host.acc(1'b1, cs, c, a, d, unused);
   endtask
   task automatic rd(input logic c, input logic [2:0] a, output logic [7:0] d);
      i_dupi_host.acc(1'b0, 1'b0, c, a, 8'h00, d);
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge CLK);
      `CHK(data_oe, 1'b0)
      RST_N = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         wr(1'b0, DUPI_SEL_CHAN_A, 3'(i), 8'hA0 | 8'(i));
         wr(1'b0, DUPI_SEL_CHAN_B, 3'(i), 8'h50 | 8'(i));
      end
      wr(1'b1, DUPI_SEL_CHAN_A, 3'h0, 8'hFF);
      for (int i = 0; i < 8; i++)
      begin
         rd(DUPI_SEL_CHAN_A, 3'(i), r);
         `CHK(r, (i == 6) ? 8'h00 : 8'hA0 | 8'(i))
         rd(DUPI_SEL_CHAN_B, 3'(i), r);
         `CHK(r, (i == 6) ? 8'h00 : 8'h50 | 8'(i))
      end
      $display("Test registers and channel routing done");
      bcast = 1'b1;
      wr(1'b0, DUPI_SEL_CHAN_B, 3'h3, 8'h3C);
      bcast = 1'b0;
      rd(DUPI_SEL_CHAN_A, 3'h3, r);
      `CHK(r, 8'h3C)
      rd(DUPI_SEL_CHAN_B, 3'h3, r);
      `CHK(r, 8'h3C)
      $display("Test broadcast write done");
      mod_a = 2'h1;
      mod_b = 2'h2;
      tx_req = 2'h3;
      repeat (4) @(negedge CLK);
      `CHK(cd_seen, 2'h1)
      `CHK(tx_go, 2'h3)
      auto_cts = 2'h3;
      @(negedge CLK);
      `CHK(tx_go, 2'h2)
      rd(DUPI_SEL_CHAN_A, DUPI_MODEM_STATUS_ADDR, r);
      `CHK(r, 8'h80)
      rd(DUPI_SEL_CHAN_B, DUPI_MODEM_STATUS_ADDR, r);
      `CHK(r, 8'h10)
      $display("Test modem status and flow control done");
      end_of_test();
   end
   // About 160 cycles of tests; some twelve times that is a hang
   initial
   begin
      #(2000 * 25);
      n_mismatch++;
      end_of_test();
   end
endmodule
bind dupi_top dupi_chk i_dupi_chk(.CLK(CLK), .RST_N(RST_N), .HOST_BUS(HOST_BUS),
   .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .MODEM_CHAN_A(MODEM_CHAN_A),
   .MODEM_CHAN_B(MODEM_CHAN_B), .ALT_FUNC_BCAST(ALT_FUNC_BCAST), .AUTO_CTS_EN(AUTO_CTS_EN),
   .TX_REQ(TX_REQ), .TX_GO(TX_GO), .CARRIER_SEEN(CARRIER_SEEN));
